// file: dv/banked_data_memory_map_bench.sv
module banked_data_memory_map_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import data_map_pkg::*;
    logic ref_clk_in = 1'h0, reset_in = 1'h1, load_bank_literal_in = 1'h0, ok;
    logic usb_enable_in = 1'h0, usb_req_in = 1'h0, usb_write_in = 1'h0, usb_ack_out;
    logic [7:0] bank_literal_in = 8'h00, usb_wdata_in = 8'h00, usb_offset_in = 8'h00;
    logic [7:0] control_rdata_in, usb_rdata_out, bank_pointer_out, control_wdata_out;
    logic control_we_out;
    logic [11:0] control_addr_out;
    core_req_s core_req_in = '0;
    core_rsp_s core_rsp_out;
    int failures = 0, comparisons = 0, cycles = 0;
    banked_data_memory_map u_banked_data_memory_map (.ref_clk_in, .reset_in, .core_req_in,
        .load_bank_literal_in, .bank_literal_in, .core_rsp_out, .bank_pointer_out, .control_rdata_in,
        .control_we_out, .control_addr_out, .control_wdata_out, .usb_enable_in, .usb_req_in,
        .usb_write_in, .usb_offset_in, .usb_wdata_in, .usb_rdata_out, .usb_ack_out);
    ctrl_space_model u_ctrl_space_model (.control_addr_in(control_addr_out), .control_rdata_out(control_rdata_in));
    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end
    // ==========
    // Tasks
    task automatic chk(string n, logic [11:0] e, logic [11:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic acc(logic w, logic f, logic b, logic [7:0] o, logic [11:0] a, logic [7:0] d);
        @(posedge ref_clk_in);
        core_req_in <= {1'h1, w, f, b, o, a, d};
        @(posedge ref_clk_in);
        core_req_in.valid <= 1'h0;
        #1;
    endtask : acc
    task automatic lit(logic [7:0] v);
        @(posedge ref_clk_in);
        load_bank_literal_in <= 1'h1;
        bank_literal_in <= v;
        @(posedge ref_clk_in);
        load_bank_literal_in <= 1'h0;
        #1;
    endtask : lit
    task automatic usb(logic w, logic [7:0] o, logic [7:0] d);
        @(posedge ref_clk_in);
        usb_req_in <= 1'h1;
        usb_write_in <= w;
        usb_offset_in <= o;
        usb_wdata_in <= d;
        @(posedge ref_clk_in);
        usb_req_in <= 1'h0;
        #1;
    endtask : usb
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    // ==========
    // Tests
    initial begin
        repeat (5) @(posedge ref_clk_in);
        reset_in <= 1'h0;
        #1 chk("pointer", 12'h000, bank_pointer_out);
        lit(8'hF2);
        chk("pointer", 12'h002, bank_pointer_out);
        acc(1'h1, 1'h0, 1'h1, 8'h10, 12'h000, 8'hA5);
        acc(1'h0, 1'h0, 1'h1, 8'h10, 12'h000, 8'h00);
        chk("addr", 12'h210, core_rsp_out.addr);
        chk("rdata", 12'h0A5, core_rsp_out.rdata);
        for (int b = 0; b < 16; b++) begin
            lit({4'hA, b[3:0]});
            acc(1'h1, 1'h0, 1'h1, 8'h33, 12'h000, 8'h5A);
            acc(1'h0, 1'h0, 1'h1, 8'h33, 12'h000, 8'h00);
            ok = b < 3 || b == 4;
            chk("rdata", ok ? 12'h05A : 12'h000, core_rsp_out.rdata);
            chk("dropped", !ok, core_rsp_out.dropped);
        end
        $display("test banks done");
        acc(1'h1, 1'h1, 1'h0, 8'h00, 12'h123, 8'hFA);
        acc(1'h0, 1'h1, 1'h0, 8'h00, 12'h123, 8'h00);
        chk("rdata", 12'h0FA, core_rsp_out.rdata);
        acc(1'h1, 1'h1, 1'h0, 8'h00, 12'h020, 8'h3C);
        acc(1'h0, 1'h0, 1'h0, 8'h20, 12'h000, 8'h00);
        chk("rdata", 12'h03C, core_rsp_out.rdata);
        acc(1'h0, 1'h0, 1'h0, 8'hD8, 12'h000, 8'h00);
        chk("addr", 12'hFD8, core_rsp_out.addr);
        chk("control_hit", 12'h001, core_rsp_out.control_hit);
        acc(1'h0, 1'h1, 1'h0, 8'h00, 12'hFE7, 8'h00);
        chk("indirect_hit", 12'h001, core_rsp_out.indirect_hit);
        chk("rdata", 12'h000, core_rsp_out.rdata);
        acc(1'h1, 1'h1, 1'h0, 8'h00, 12'hFE0, 8'hB7);
        chk("pointer", 12'h007, bank_pointer_out);
        chk("control_we", 12'h000, control_we_out);
        acc(1'h1, 1'h0, 1'h0, 8'h80, 12'h000, 8'h3E);
        chk("control_we", 12'h001, control_we_out);
        chk("control_addr", 12'hF80, control_addr_out);
        chk("control_wdata", 12'h03E, control_wdata_out);
        $display("test windows done");
        @(posedge ref_clk_in);
        usb_enable_in <= 1'h1;
        usb(1'h1, 8'h05, 8'h77);
        chk("ack", 12'h001, usb_ack_out);
        lit(8'h04);
        acc(1'h0, 1'h0, 1'h1, 8'h05, 12'h000, 8'h00);
        chk("rdata", 12'h077, core_rsp_out.rdata);
        acc(1'h1, 1'h0, 1'h1, 8'h06, 12'h000, 8'h99);
        usb(1'h0, 8'h06, 8'h00);
        chk("usb_rdata", 12'h099, usb_rdata_out);
        $display("test usb done");
        results();
    end
endmodule : banked_data_memory_map_bench

// file: dv/ctrl_space_model.sv
module ctrl_space_model (
    // Control space
    input wire logic [11:0] control_addr_in,
    output logic [7:0] control_rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    assign control_rdata_out = ~control_addr_in[7:0];
endmodule : ctrl_space_model

// file: dv/data_map_props.sv
module data_map_props
    import data_map_pkg::*;
(
    // Watched ports
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire data_map_pkg::core_req_s core_req_in,
    input wire logic load_bank_literal_in,
    input wire logic [7:0] bank_literal_in,
    input wire data_map_pkg::core_rsp_s core_rsp_out,
    input wire logic [7:0] bank_pointer_out,
    input wire logic usb_enable_in,
    input wire logic usb_req_in,
    input wire logic usb_ack_out
);
    // ==========
    // Properties
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    logic bk;
    logic fw;
    assign bk = core_req_in.valid && !core_req_in.full_move && core_req_in.bank_sel;
    assign fw = core_req_in.valid && !core_req_in.full_move && !core_req_in.bank_sel;
    rsp_latency_a: assert property (core_req_in.valid |=> core_rsp_out.valid)
        else $error("no response one cycle after request");
    ptr_upper_a: assert property (bank_pointer_out[7:4] == 4'h0)
        else $error("pointer upper bits not zero");
    lit_load_a: assert property (load_bank_literal_in |=> bank_pointer_out == ($past(bank_literal_in) & 8'h0F))
        else $error("literal not loaded into pointer");
    banked_addr_a: assert property (bk |=> core_rsp_out.addr == {$past(bank_pointer_out[3:0]), $past(core_req_in.offset)})
        else $error("banked address wrong");
    full_addr_a: assert property (core_req_in.valid && core_req_in.full_move |=> core_rsp_out.addr == $past(core_req_in.full_addr))
        else $error("full address wrong");
    fast_low_a: assert property (fw && core_req_in.offset < 8'h60 |=> core_rsp_out.addr == {4'h0, $past(core_req_in.offset)})
        else $error("fast window low map wrong");
    fast_high_a: assert property (fw && core_req_in.offset >= 8'h60 |=> core_rsp_out.addr == {4'hF, $past(core_req_in.offset)})
        else $error("fast window high map wrong");
    usb_ack_a: assert property (usb_enable_in && usb_req_in |=> usb_ack_out)
        else $error("usb port not acknowledged");
    cover property (bk ##1 core_rsp_out.dropped);
    cover property (fw ##1 core_rsp_out.control_hit);
    cover property (usb_enable_in && usb_req_in);
endmodule : data_map_props

bind banked_data_memory_map data_map_props u_data_map_props (.ref_clk_in, .reset_in, .core_req_in,
    .load_bank_literal_in, .bank_literal_in, .core_rsp_out, .bank_pointer_out, .usb_enable_in, .usb_req_in,
    .usb_ack_out);

// file: rtl/banked_data_memory_map.sv
// Function
// - Every data location has a 12-bit address, 4096 bytes of space.
// - The space is split into 16 banks of 256 bytes.
// - Only four banks, 1024 bytes (banks 0 to 2 and bank 4), hold real storage.
// - Reading any unimplemented location returns zero.
// - A 256-byte fast window reaches control registers and bottom of bank 0.
// - Bank 4 is dual-port and plain storage while USB is off.
// - With USB on, bank 4 is buffer space shared with the serial engine.
// - Banked address is bank pointer above the 8-bit instruction offset.
// - Only the low four bank pointer bits store; upper bits read zero.
// - Load-bank-literal writes its immediate straight into the bank pointer.
// - Writes to missing banks drop, reads give zero, status still updates.
// - Full-address move uses complete 12-bit addresses and ignores the pointer.
// - Other instructions use bank pointer or fast window with low offset.
// - Control registers occupy F60h to FFFh at the top of bank 15.
// - Indirect operand addresses hold no storage; they act via pointers.
// - Fast window offsets 00h to 5Fh map to the bottom of bank 0.
// - Access-select bit one uses the bank pointer, zero the fast window.
module banked_data_memory_map #(
    parameter int STORE_BANKS_P = data_map_pkg::STORE_BANKS
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Core access
    input wire data_map_pkg::core_req_s core_req_in,
    input wire logic load_bank_literal_in,
    input wire logic [7:0] bank_literal_in,
    output data_map_pkg::core_rsp_s core_rsp_out,
    output logic [7:0] bank_pointer_out,
    // Control register space, served outside
    input wire logic [7:0] control_rdata_in,
    output logic control_we_out,
    output logic [data_map_pkg::ADDR_W-1:0] control_addr_out,
    output logic [7:0] control_wdata_out,
    // USB serial engine port on bank 4
    input wire logic usb_enable_in,
    input wire logic usb_req_in,
    input wire logic usb_write_in,
    input wire logic [data_map_pkg::OFFS_W-1:0] usb_offset_in,
    input wire logic [7:0] usb_wdata_in,
    output logic [7:0] usb_rdata_out,
    output logic usb_ack_out
);
    import data_map_pkg::*;

    // ==========================================================
    // Storage: banks 0..STORE_BANKS_P-1 plus the dual-port bank 4
    logic [7:0] main_mem [STORE_BANKS_P*BANK_BYTES];
    logic [7:0] usb_mem [BANK_BYTES];

    function automatic logic bank_stored(input logic [BANK_W-1:0] b);
        return (32'(b) < STORE_BANKS_P) || (b == USB_BANK);
    endfunction : bank_stored

    function automatic logic is_indirect(input logic [ADDR_W-1:0] a);
        return (a == INDIRECT_0_ADDR) || (a == INDIRECT_1_ADDR) || (a == INDIRECT_2_ADDR);
    endfunction : is_indirect

    // ==========================================================
    // Address formation
    addr_mode_e mode;
    logic [ADDR_W-1:0] eff_addr;
    logic [BANK_W-1:0] eff_bank;
    logic [OFFS_W-1:0] eff_offs;
    logic [7:0] bank_pointer_q;
    logic [7:0] bank_pointer_d;

    always_comb begin
        if (core_req_in.full_move) begin
            mode = MODE_FULL;
        end else if (core_req_in.bank_sel) begin
            mode = MODE_BANKED;
        end else begin
            mode = MODE_FAST;
        end
        case (mode)
            MODE_FULL: begin
                eff_addr = core_req_in.full_addr;
            end
            MODE_BANKED: begin
                eff_addr = {bank_pointer_q[BANK_W-1:0], core_req_in.offset};
            end
            MODE_FAST: begin
                if (core_req_in.offset < FAST_SPLIT) begin
                    eff_addr = {4'h0, core_req_in.offset};
                end else begin
                    eff_addr = {CTRL_BANK, core_req_in.offset};
                end
            end
            default: begin
                eff_addr = {ADDR_W{1'b0}};
            end
        endcase
        eff_bank = eff_addr[ADDR_W-1:OFFS_W];
        eff_offs = eff_addr[OFFS_W-1:0];
    end

    // ==========================================================
    // Region decode
    logic hit_ctrl;
    logic hit_indirect;
    logic hit_bank_ptr;
    logic hit_main;
    logic hit_usb;
    logic core_wr;

    always_comb begin
        hit_ctrl = (eff_addr >= CTRL_BASE);
        hit_indirect = is_indirect(eff_addr);
        hit_bank_ptr = (eff_addr == BANK_PTR_ADDR);
        hit_usb = (eff_bank == USB_BANK);
        hit_main = !hit_ctrl && bank_stored(eff_bank) && !hit_usb;
        core_wr = core_req_in.valid && core_req_in.write;
    end

    // ==========================================================
    // Bank pointer
    always_comb begin
        bank_pointer_d = bank_pointer_q;
        if (load_bank_literal_in) begin
            bank_pointer_d = bank_literal_in & BANK_PTR_MASK;
        end else if (core_wr && hit_bank_ptr) begin
            bank_pointer_d = core_req_in.wdata & BANK_PTR_MASK;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            bank_pointer_q <= BANK_PTR_RESET;
        end else begin
            bank_pointer_q <= bank_pointer_d;
        end
    end

    // ==========================================================
    // Storage writes; unmapped writes fall through
    logic usb_wr;
    assign usb_wr = usb_enable_in && usb_req_in && usb_write_in;

    always_ff @(posedge ref_clk_in) begin
        if (core_wr && hit_main) begin
            main_mem[eff_addr[9:0]] <= core_req_in.wdata;
        end
        // Serial engine takes priority on collisions while USB runs
        if (usb_wr) begin
            usb_mem[usb_offset_in] <= usb_wdata_in;
        end else if (core_wr && hit_usb) begin
            usb_mem[eff_offs] <= core_req_in.wdata;
        end
    end

    // ==========================================================
    // Read data and response register
    core_rsp_s rsp_d;
    core_rsp_s rsp_q;
    logic [7:0] usb_rdata_d;
    logic usb_ack_d;

    always_comb begin
        rsp_d = '0;
        rsp_d.valid = core_req_in.valid;
        rsp_d.addr = eff_addr;
        rsp_d.control_hit = core_req_in.valid && hit_ctrl;
        rsp_d.indirect_hit = core_req_in.valid && hit_indirect;
        rsp_d.indirect_sel = (eff_addr == INDIRECT_0_ADDR) ? 2'h0 :
                             (eff_addr == INDIRECT_1_ADDR) ? 2'h1 : 2'h2;
        // Status updates regardless: dropped is advisory only
        rsp_d.dropped = core_req_in.valid && !hit_ctrl && !hit_main && !hit_usb;
        if (!core_req_in.valid || core_req_in.write) begin
            rsp_d.rdata = 8'h00;
        end else if (hit_bank_ptr) begin
            rsp_d.rdata = bank_pointer_q;
        end else if (hit_indirect) begin
            rsp_d.rdata = 8'h00;
        end else if (hit_ctrl) begin
            rsp_d.rdata = control_rdata_in;
        end else if (hit_main) begin
            rsp_d.rdata = main_mem[eff_addr[9:0]];
        end else if (hit_usb) begin
            rsp_d.rdata = usb_mem[eff_offs];
        end else begin
            rsp_d.rdata = 8'h00;
        end
        usb_ack_d = usb_enable_in && usb_req_in;
        usb_rdata_d = (usb_enable_in && usb_req_in && !usb_write_in) ? usb_mem[usb_offset_in] : 8'h00;
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rsp_q <= '0;
            usb_rdata_out <= 8'h00;
            usb_ack_out <= 1'b0;
            control_we_out <= 1'b0;
            control_addr_out <= {ADDR_W{1'b0}};
            control_wdata_out <= 8'h00;
        end else begin
            rsp_q <= rsp_d;
            usb_rdata_out <= usb_rdata_d;
            usb_ack_out <= usb_ack_d;
            control_we_out <= core_wr && hit_ctrl && !hit_bank_ptr && !hit_indirect;
            control_addr_out <= eff_addr;
            control_wdata_out <= core_req_in.wdata;
        end
    end

    assign core_rsp_out = rsp_q;
    assign bank_pointer_out = bank_pointer_q;

endmodule : banked_data_memory_map

// file: rtl/data_map_pkg.sv
package data_map_pkg;

    // ==========================================================
    // Address geometry
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int OFFS_W = 8;
    localparam int BANK_COUNT = 16;
    localparam int BANK_BYTES = 256;
    localparam int STORE_BANKS = 3;
    localparam int STORE_BYTES = 768;

    // ==========================================================
    // Fixed locations
    localparam logic [BANK_W-1:0] USB_BANK = 4'h4;
    localparam logic [BANK_W-1:0] CTRL_BANK = 4'hF;
    localparam logic [ADDR_W-1:0] CTRL_BASE = 12'hF60;
    localparam logic [ADDR_W-1:0] CTRL_TOP = 12'hFFF;
    localparam logic [ADDR_W-1:0] BANK_PTR_ADDR = 12'hFE0;
    localparam logic [ADDR_W-1:0] INDIRECT_0_ADDR = 12'hFEF;
    localparam logic [ADDR_W-1:0] INDIRECT_1_ADDR = 12'hFE7;
    localparam logic [ADDR_W-1:0] INDIRECT_2_ADDR = 12'hFDF;
    localparam logic [OFFS_W-1:0] FAST_SPLIT = 8'h60;
    localparam logic [7:0] BANK_PTR_RESET = 8'h00;
    localparam logic [7:0] BANK_PTR_MASK = 8'h0F;

    // ==========================================================
    // Access request from the core and response to it
    typedef enum logic [2:0] {
        MODE_BANKED = 3'b001,
        MODE_FAST = 3'b010,
        MODE_FULL = 3'b100
    } addr_mode_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic full_move;
        logic bank_sel;
        logic [OFFS_W-1:0] offset;
        logic [ADDR_W-1:0] full_addr;
        logic [7:0] wdata;
    } core_req_s;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [7:0] rdata;
        logic dropped;
        logic control_hit;
        logic indirect_hit;
        logic [1:0] indirect_sel;
    } core_rsp_s;

endpackage : data_map_pkg
